// *** verilog/sram_ctl_pkg.sv ***
/*
  Package for the asynchronous static memory controller: widths, timing
  figures and derived cycle counts at a 250 MHz clock, command and pin
  bundles.
  Assumes a 4 ns clock period; every count rounds a least time upward.
*/
package sram_ctl_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  localparam int CLK_PS = 4000;

  // Figures in their own unit
  localparam int T_POWER_US = 100;
  localparam int T_RC_NS    = 10;
  localparam int T_AA_NS    = 10;
  localparam int T_DOE_NS   = 5;
  localparam int T_HZOE_NS  = 5;
  localparam int T_WC_NS    = 10;
  localparam int T_AW_NS    = 7;
  localparam int T_PWE_NS   = 7;
  localparam int T_SD_NS    = 6;
  localparam int T_HZWE_NS  = 5;

  function automatic int cyc_up(input int t_ps);
    int c;
    c = (t_ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Derived cycle counts
  localparam int POWER_CYC = cyc_up(T_POWER_US * 1000000);
  localparam int READ_CYC  = cyc_up(T_AA_NS * 1000) + 1;
  localparam int TURN_CYC  = cyc_up(T_HZOE_NS * 1000);
  localparam int WLOW_CYC  = cyc_up((T_HZWE_NS + T_SD_NS) * 1000);
  localparam int WMIN_CYC  = cyc_up(T_PWE_NS * 1000);
  localparam int WCYC_CYC  = cyc_up(T_WC_NS * 1000);

  localparam int CNT_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_type;

  typedef struct packed {
    logic              n_ce;
    logic              n_oe;
    logic              n_we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              doe;
  } pins_type;

endpackage

// *** verilog/power_wait.sv ***
/*
  Power-up wait: holds ready low for a programmable number of cycles
  after reset release.
  Assumes reset is released once the supply stands at its typical level.
*/
`timescale 1ns/10ps
module power_wait
  import sram_ctl_pkg::*;
#(
  parameter int WAIT_CYC = POWER_CYC
)
(
  input  wire logic I_CLK,
  input  wire logic I_NRST,
  output logic      o_ready
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             rdy_ff;
  logic             nxt_rdy;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_rdy = rdy_ff;
    if (!rdy_ff)
    begin
      if (cnt_ff >= CNT_W'(WAIT_CYC - 1))
        nxt_rdy = 1'b1;
      else
        nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      cnt_ff <= '0;
      rdy_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_rdy;
    end
  end

  assign o_ready = rdy_ff;

endmodule

// *** verilog/sram_ctl.sv ***
/*
  Controller for a 128 K x 8 asynchronous static memory: takes single
  byte read and write requests and drives chip select, output enable,
  write strobe, address and the shared data lines.
  Assumes the memory is wired straight to the pins; data lines are
  resolved outside from the output enable.
*/
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// What this block does
// - Write data is held at least 6 ns before and 0 ns after the edge that ends the write.
// - Address is stable from write start, at least 7 ns before write end, until the write ends.
// - The first access waits at least 100 us after the supply is up.
// - The controller never drives the data lines while the memory may be driving them.
// - A strobe-controlled write with output enable low lasts at least turn-off plus set-up time.
// - Address is valid no later than the fall of chip select for a read.
module sram_ctl
  import sram_ctl_pkg::*;
#(
  parameter int WAIT_CYC = POWER_CYC
)
(
  input  wire logic              I_CLK,
  input  wire logic              I_NRST,
  input  wire logic              I_REQ_VALID,
  input  wire logic              I_REQ_WR,
  input  wire logic [ADDR_W-1:0] I_REQ_ADDR,
  input  wire logic [DATA_W-1:0] I_REQ_WDATA,
  output logic                   O_REQ_READY,
  output logic                   O_RD_VALID,
  output logic      [DATA_W-1:0] O_RD_DATA,
  output logic                   O_CE_N,
  output logic                   O_OE_N,
  output logic                   O_WE_N,
  output logic      [ADDR_W-1:0] O_ADDRESS_LINES,
  input  wire logic [DATA_W-1:0] I_DATA_LINES,
  output logic      [DATA_W-1:0] O_DATA_LINES,
  output logic                   O_DATA_LINES_OE
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_READ  = 5'b00010,
    ST_WSET  = 5'b00100,
    ST_WLOW  = 5'b01000,
    ST_WEND  = 5'b10000
  } state_type;

  ////////////////////////////////////////////////////////////////////////
  // Power-up wait

  logic pwr_ready;

  power_wait #(
    .WAIT_CYC (WAIT_CYC)
  ) u_power_wait (
    .I_CLK   (I_CLK),
    .I_NRST  (I_NRST),
    .o_ready (pwr_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data synchroniser

  logic [DATA_W-1:0] din_s1_ff;
  logic [DATA_W-1:0] din_s2_ff;

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      din_s1_ff <= DATA_RST;
      din_s2_ff <= DATA_RST;
    end
    else
    begin
      din_s1_ff <= I_DATA_LINES;
      din_s2_ff <= din_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access sequencer

  state_type        state_ff;
  state_type        nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  pins_type         pins_ff;
  pins_type         nxt_pins;
  logic             rdv_ff;
  logic             nxt_rdv;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  localparam pins_type PINS_RST = '{n_ce: 1'b1, n_oe: 1'b1, n_we: 1'b1,
                                    addr: ADDR_RST, dout: DATA_RST, doe: 1'b0};

  // Read window covers access time plus two synchroniser stages
  localparam int RD_WAIT = READ_CYC + 2;
  localparam int WL_WAIT = (WLOW_CYC > WMIN_CYC) ? WLOW_CYC : WMIN_CYC;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_pins  = pins_ff;
    nxt_rdv   = 1'b0;
    nxt_rdata = rdata_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        nxt_pins.n_ce = 1'b1;
        nxt_pins.n_oe = 1'b1;
        nxt_pins.n_we = 1'b1;
        nxt_pins.doe  = 1'b0;
        if (I_REQ_VALID && pwr_ready)
        begin
          nxt_pins.addr = I_REQ_ADDR;
          nxt_pins.n_ce = 1'b0;
          nxt_cnt       = '0;
          if (I_REQ_WR)
          begin
            nxt_pins.dout = I_REQ_WDATA;
            nxt_state     = ST_WSET;
          end
          else
          begin
            nxt_pins.n_oe = 1'b0;
            nxt_state     = ST_READ;
          end
        end
      end
      ST_READ:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff >= CNT_W'(RD_WAIT - 1))
        begin
          nxt_rdata     = din_s2_ff;
          nxt_rdv       = 1'b1;
          nxt_pins.n_ce = 1'b1;
          nxt_pins.n_oe = 1'b1;
          nxt_cnt       = '0;
          nxt_state     = ST_WEND;
        end
      end
      ST_WSET:
      begin
        // Output enable stays high, memory floats before controller drives
        nxt_pins.n_we = 1'b0;
        nxt_cnt       = '0;
        nxt_state     = ST_WLOW;
      end
      ST_WLOW:
      begin
        nxt_pins.doe = 1'b1;
        nxt_cnt      = cnt_ff + 1'b1;
        if (cnt_ff >= CNT_W'(WL_WAIT - 1))
        begin
          nxt_pins.n_we = 1'b1;
          nxt_cnt       = '0;
          nxt_state     = ST_WEND;
        end
      end
      ST_WEND:
      begin
        // Hold data and address one cycle past strobe rise, then release
        nxt_pins.n_ce = 1'b1;
        nxt_pins.doe  = 1'b0;
        nxt_cnt       = cnt_ff + 1'b1;
        if (cnt_ff >= CNT_W'(TURN_CYC - 1))
        begin
          nxt_cnt   = '0;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_pins  = PINS_RST;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      pins_ff  <= PINS_RST;
      rdv_ff   <= 1'b0;
      rdata_ff <= DATA_RST;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      pins_ff  <= nxt_pins;
      rdv_ff   <= nxt_rdv;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign O_REQ_READY     = (state_ff == ST_IDLE) && pwr_ready;
  assign O_RD_VALID      = rdv_ff;
  assign O_RD_DATA       = rdata_ff;
  assign O_CE_N          = pins_ff.n_ce;
  assign O_OE_N          = pins_ff.n_oe;
  assign O_WE_N          = pins_ff.n_we;
  assign O_ADDRESS_LINES = pins_ff.addr;
  assign O_DATA_LINES    = pins_ff.dout;
  assign O_DATA_LINES_OE = pins_ff.doe;

endmodule

// *** sim/sram_ctl_sva.sv ***
/* Pin checker for the memory controller.
   Assumes it is bound into sram_ctl with the same WAIT_CYC. */
`timescale 1ns/10ps
module sram_ctl_chk
  import sram_ctl_pkg::*;
#(
  parameter int WAIT_CYC = POWER_CYC
)
(
  input wire logic              I_CLK,
  input wire logic              I_NRST,
  input wire logic [ADDR_W-1:0] I_REQ_ADDR,
  input wire logic              O_REQ_READY,
  input wire logic              O_RD_VALID,
  input wire logic              O_CE_N,
  input wire logic              O_OE_N,
  input wire logic              O_WE_N,
  input wire logic [ADDR_W-1:0] O_ADDRESS_LINES,
  input wire logic              O_DATA_LINES_OE
);
  logic [CNT_W-1:0] up_ff;
  logic [CNT_W-1:0] nxt_up;
  always_comb nxt_up = (up_ff < CNT_W'(WAIT_CYC)) ? up_ff + 1'b1 : up_ff;
  always_ff @(posedge I_CLK or negedge I_NRST)
    if (!I_NRST) up_ff <= '0;
    else up_ff <= nxt_up;
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  a_power_wait: assert property (O_REQ_READY |-> up_ff >= CNT_W'(WAIT_CYC))
    else $error("ready too early");
  a_we_sel: assert property (!O_WE_N |-> !O_CE_N)
    else $error("write strobe without select");
  a_ce_late: assert property ($rose(O_WE_N) |-> !O_CE_N ##1 O_CE_N)
    else $error("select release wrong");
  a_data_setup: assert property ($rose(O_WE_N) |-> $past(O_DATA_LINES_OE, 2) && O_DATA_LINES_OE)
    else $error("write data window short");
  a_addr_hold: assert property (!O_WE_N |-> $stable(O_ADDRESS_LINES))
    else $error("address moved in write");
  a_addr_req: assert property ($fell(O_CE_N) |-> O_ADDRESS_LINES == $past(I_REQ_ADDR))
    else $error("address late at select");
  a_no_fight: assert property (O_DATA_LINES_OE |-> O_OE_N && !O_CE_N)
    else $error("data driven against memory");
  a_we_width: assert property ($fell(O_WE_N) |-> !O_WE_N [*3] ##1 O_WE_N)
    else $error("write strobe width");
  a_read_len: assert property ($fell(O_OE_N) |-> !O_OE_N [*6] ##1 (O_OE_N && O_RD_VALID))
    else $error("read wait wrong");
endmodule
bind sram_ctl sram_ctl_chk #(.WAIT_CYC(WAIT_CYC)) u_chk (.I_CLK, .I_NRST, .I_REQ_ADDR,
  .O_REQ_READY, .O_RD_VALID, .O_CE_N, .O_OE_N, .O_WE_N, .O_ADDRESS_LINES, .O_DATA_LINES_OE);

// *** sim/sram_model.sv ***
/* Behavioural 128 K x 8 asynchronous memory.
   Assumes the bench resolves the shared data lines from o_drive. */
`timescale 1ns/10ps
module sram_model
  import sram_ctl_pkg::*;
(
  input  wire logic              i_ce_n,
  input  wire logic              i_oe_n,
  input  wire logic              i_we_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_data,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_drive
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic              wr;
  assign wr = !i_ce_n && !i_we_n;
  assign o_drive = !i_ce_n && !i_oe_n && i_we_n;
  // Write lands when the overlap ends
  always @(negedge wr) mem[i_addr] = i_data;
  // Old data briefly, garbage, then the byte
  always @(i_addr or i_ce_n or i_oe_n)
  begin
    o_data <= #3 ~mem[i_addr];
    o_data <= #10 mem[i_addr];
  end
endmodule

// *** sim/tb.sv ***
/* Testbench for sram_ctl driving a behavioural memory.
   Assumes sram_model and the bound checker are compiled with it. */
`timescale 1ns/10ps
module tb
  import sram_ctl_pkg::*;
;
  localparam int WAIT = 20;
  logic              clk, nrst, req_valid, req_wr, ready, rd_valid;
  logic              ce_n, oe_n, we_n, dut_oe, mem_drv;
  logic [ADDR_W-1:0] req_addr, pin_addr;
  logic [DATA_W-1:0] req_wdata, rd_data, dut_q, mem_q, float_q, line_q;
  int                fails, total_checks;
  assign line_q = dut_oe ? dut_q : (mem_drv ? mem_q : float_q);
  always @(posedge clk) float_q <= ~float_q;
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  sram_ctl #(.WAIT_CYC(WAIT)) u_dut (.I_CLK(clk), .I_NRST(nrst), .I_REQ_VALID(req_valid),
    .I_REQ_WR(req_wr), .I_REQ_ADDR(req_addr), .I_REQ_WDATA(req_wdata), .O_REQ_READY(ready),
    .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .O_CE_N(ce_n), .O_OE_N(oe_n), .O_WE_N(we_n),
    .O_ADDRESS_LINES(pin_addr), .I_DATA_LINES(line_q), .O_DATA_LINES(dut_q),
    .O_DATA_LINES_OE(dut_oe));
  sram_model u_mem (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(pin_addr),
    .i_data(line_q), .o_data(mem_q), .o_drive(mem_drv));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic send(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 200)
    begin
      fails++;
      results;
    end
    req_valid = 1'b1;
    req_wr = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    send(1'b0, a, 8'h00);
    n = 0;
    while (rd_valid !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'(READ_CYC + 2));
    if (n == 20) results;
    chk(rd_data, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Idle pins and no ready during the power wait
  task automatic t_power;
    repeat (WAIT - 2) @(negedge clk);
    chk({5'h00, ready, ce_n, dut_oe}, 8'h02);
    @(negedge clk);
    chk({7'h00, ready}, 8'h00);
    @(negedge clk);
    chk({7'h00, ready}, 8'h01);
  endtask
  // Back-to-back writes at both address ends, read back, overwrite
  task automatic t_rw;
    logic [ADDR_W-1:0] a [3];
    a = '{17'h0_0000, 17'h1_FFFF, 17'h0_5555};
    for (int i = 0; i < 3; i++) send(1'b1, a[i], a[i][7:0] ^ 8'hC3);
    for (int i = 0; i < 3; i++) rd(a[i], a[i][7:0] ^ 8'hC3);
    send(1'b1, 17'h1_FFFF, 8'h5A);
    rd(17'h1_FFFF, 8'h5A);
  endtask
  // Second reset: pins released, memory keeps its data
  task automatic t_reset;
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    chk({3'h0, ce_n, oe_n, we_n, dut_oe, ready}, 8'h1C);
    nrst = 1'b1;
    rd(17'h0_5555, 8'h96);
  endtask
  initial
  begin
    fails = 0;
    total_checks = 0;
    nrst = 1'b0;
    req_valid = 1'b0;
    req_wr = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    float_q = 8'hA5;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_power;
    t_rw;
    t_reset;
    results;
  end
endmodule
